// [design/jtp_pin_if.sv]
// Purpose: carries cleaned test pin levels and test clock edges between modules
// Assumes: all signals on the core clock
// Notes: edges are one-cycle pulses
interface jtp_pin_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic ce_n;
  modport drv (output tck_rise, output tck_fall, output tms, output tdi, output ce_n);
  modport tap (input tck_rise, input tck_fall, input tms, input tdi, input ce_n);
endinterface

// [design/jtp_pin_sync.sv]
// Purpose: three-stage synchroniser and edge finder for the test pins
// Assumes: pins are asynchronous to core_clk_in
// Notes: a level counts once the second and third stages agree
module jtp_pin_sync (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic chip_enable_n_in,
  jtp_pin_if.drv pin
);
  logic [jtp_pkg::PIN_W-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [jtp_pkg::PIN_W-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;
  logic rise_r, fall_r, rise_nxt, fall_nxt;

  // stage chain, filter and edge detection
  always_comb
  begin
    s1_nxt = {chip_enable_n_in, tdi_in, tms_in, tck_in};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    filt_nxt = filt_r;
    for (int i = 0; i < jtp_pkg::PIN_W; i++)
    begin
      if (s2_r[i] == s3_r[i])
      begin
        filt_nxt[i] = s3_r[i];
      end
    end
    rise_nxt = filt_nxt[jtp_pkg::PIN_TCK] & ~filt_r[jtp_pkg::PIN_TCK];
    fall_nxt = ~filt_nxt[jtp_pkg::PIN_TCK] & filt_r[jtp_pkg::PIN_TCK];
  end

  // registers, idle pin levels after reset
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      s1_r <= jtp_pkg::PIN_IDLE;
      s2_r <= jtp_pkg::PIN_IDLE;
      s3_r <= jtp_pkg::PIN_IDLE;
      filt_r <= jtp_pkg::PIN_IDLE;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      filt_r <= filt_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  // hand cleaned levels to the controller
  assign pin.tck_rise = rise_r;
  assign pin.tck_fall = fall_r;
  assign pin.tms = filt_r[jtp_pkg::PIN_TMS];
  assign pin.tdi = filt_r[jtp_pkg::PIN_TDI];
  assign pin.ce_n = filt_r[jtp_pkg::PIN_CEN];
endmodule

// [design/jtp_pkg.sv]
// Purpose: shared constants and types of the test access port block
// Assumes: pins arrive unsynchronised; the core clock is far faster than the test clock
// Notes: pin vector order is {chip_enable_n, tdi, tms, tck}
// Notes on behaviour
// (RULE1) the serial bit on tdi is taken into the active shift path at each rising test clock edge.
// (RULE2) the serial bit on tdo changes only at a falling test clock edge during shifting.
// (RULE3) tdo is released (enable low) whenever nothing is being shifted out.
// (RULE4) the controller moves only on a rising test clock edge, steered by tms sampled there.
// (RULE5) the host keeps all test pins steady before and during device configuration.
// (RULE6) tdi and tms held high with tck low leave the test logic idle in its reset state.
// (RULE7) the host holds chip_enable_n low for the whole of programming through the port.
// (RULE8) the controller is the standard sixteen-state machine with both ir and dr paths.
package jtp_pkg;
  // synchroniser
  localparam int SYNC_STAGES = 3;
  localparam int PIN_W = 4;
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_CEN = 3;
  localparam logic [PIN_W-1:0] PIN_IDLE = 4'he;

  // instruction path
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] INSTR_USER = 4'h2;
  localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_RESET = INSTR_IDCODE;

  // data path and reset walk counts
  localparam int ID_W = 32;
  localparam logic [ID_W-1:0] ID_CODE_DEFAULT = 32'h0000_0001; // arbitrary value
  localparam int USER_W = 8;
  localparam int RESET_TMS_RISES = 5;
  localparam logic [2:0] ONES_MAX = 3'h5;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtp_state_t;
endpackage

// [design/jtp_tap_port.sv]
// Purpose: test access port controller with ir, bypass, id and user data paths
// Assumes: test clock well below a quarter of the core clock
// Notes: tdo has a data and an enable output; the pad is outside
module jtp_tap_port #(
  parameter int USER_W = jtp_pkg::USER_W,
  parameter logic [jtp_pkg::ID_W-1:0] ID_CODE = jtp_pkg::ID_CODE_DEFAULT // arbitrary value
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic chip_enable_n_in,
  input wire logic [USER_W-1:0] user_capture_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic [jtp_pkg::IR_W-1:0] instr_out,
  output logic [USER_W-1:0] user_data_out,
  output logic user_update_out
);
  localparam int IR_W = jtp_pkg::IR_W;
  localparam int ID_W = jtp_pkg::ID_W;

  jtp_pin_if pin ();

  jtp_pin_sync u_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .tck_in(tck_in),
    .tms_in(tms_in),
    .tdi_in(tdi_in),
    .chip_enable_n_in(chip_enable_n_in),
    .pin(pin)
  );

  // standard controller transition table
  function automatic jtp_pkg::jtp_state_t tap_next(input jtp_pkg::jtp_state_t s,
                                                   input logic tms);
    case (s)
      jtp_pkg::ST_TLR: tap_next = tms ? jtp_pkg::ST_TLR : jtp_pkg::ST_RTI;
      jtp_pkg::ST_RTI: tap_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
      jtp_pkg::ST_SEL_DR: tap_next = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      jtp_pkg::ST_CAP_DR: tap_next = tms ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
      jtp_pkg::ST_SHIFT_DR: tap_next = tms ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
      jtp_pkg::ST_EXIT1_DR: tap_next = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAUSE_DR;
      jtp_pkg::ST_PAUSE_DR: tap_next = tms ? jtp_pkg::ST_EXIT2_DR : jtp_pkg::ST_PAUSE_DR;
      jtp_pkg::ST_EXIT2_DR: tap_next = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SHIFT_DR;
      jtp_pkg::ST_UPD_DR: tap_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
      jtp_pkg::ST_SEL_IR: tap_next = tms ? jtp_pkg::ST_TLR : jtp_pkg::ST_CAP_IR;
      jtp_pkg::ST_CAP_IR: tap_next = tms ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
      jtp_pkg::ST_SHIFT_IR: tap_next = tms ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
      jtp_pkg::ST_EXIT1_IR: tap_next = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAUSE_IR;
      jtp_pkg::ST_PAUSE_IR: tap_next = tms ? jtp_pkg::ST_EXIT2_IR : jtp_pkg::ST_PAUSE_IR;
      jtp_pkg::ST_EXIT2_IR: tap_next = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SHIFT_IR;
      jtp_pkg::ST_UPD_IR: tap_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
      default: tap_next = jtp_pkg::ST_TLR;
    endcase
  endfunction

  jtp_pkg::jtp_state_t state_r, state_nxt;
  logic [IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
  logic byp_r, byp_nxt;
  logic [ID_W-1:0] id_sh_r, id_sh_nxt;
  logic [USER_W-1:0] usr_sh_r, usr_sh_nxt, usr_q_r, usr_q_nxt;
  logic upd_r, upd_nxt;
  logic tdo_r, tdo_nxt, oe_r, oe_nxt;
  logic [2:0] ones_r, ones_nxt;
  logic shifting;
  logic dr_bit;

  assign shifting = (state_r == jtp_pkg::ST_SHIFT_IR) || (state_r == jtp_pkg::ST_SHIFT_DR);

  // serial bit of the selected data path
  always_comb
  begin
    if (ir_r == jtp_pkg::INSTR_IDCODE)
    begin
      dr_bit = id_sh_r[0];
    end
    else if (ir_r == jtp_pkg::INSTR_USER)
    begin
      dr_bit = usr_sh_r[0];
    end
    else
    begin
      dr_bit = byp_r;
    end
  end

  // controller, shift paths and tdo next values
  always_comb
  begin
    state_nxt = state_r;
    ir_nxt = ir_r;
    ir_sh_nxt = ir_sh_r;
    byp_nxt = byp_r;
    id_sh_nxt = id_sh_r;
    usr_sh_nxt = usr_sh_r;
    usr_q_nxt = usr_q_r;
    upd_nxt = 1'b0;
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    if (pin.tck_rise)
    begin
      state_nxt = tap_next(state_r, pin.tms); // RULE4 RULE8
      case (state_r)
        jtp_pkg::ST_TLR: ir_nxt = jtp_pkg::IR_RESET; // RULE6
        jtp_pkg::ST_CAP_IR: ir_sh_nxt = jtp_pkg::IR_CAPTURE;
        jtp_pkg::ST_SHIFT_IR: ir_sh_nxt = {pin.tdi, ir_sh_r[IR_W-1:1]}; // RULE1
        jtp_pkg::ST_UPD_IR: ir_nxt = ir_sh_r;
        jtp_pkg::ST_CAP_DR:
        begin
          byp_nxt = 1'b0;
          id_sh_nxt = ID_CODE;
          usr_sh_nxt = user_capture_in;
        end
        jtp_pkg::ST_SHIFT_DR:
        begin
          // RULE1
          if (ir_r == jtp_pkg::INSTR_IDCODE)
          begin
            id_sh_nxt = {pin.tdi, id_sh_r[ID_W-1:1]};
          end
          else if (ir_r == jtp_pkg::INSTR_USER)
          begin
            usr_sh_nxt = {pin.tdi, usr_sh_r[USER_W-1:1]};
          end
          else
          begin
            byp_nxt = pin.tdi;
          end
        end
        jtp_pkg::ST_UPD_DR:
        begin
          // user update only while the host holds chip enable low
          if (ir_r == jtp_pkg::INSTR_USER && !pin.ce_n) // RULE7
          begin
            usr_q_nxt = usr_sh_r;
            upd_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (pin.tck_fall)
    begin
      oe_nxt = shifting; // RULE3
      if (shifting)
      begin
        tdo_nxt = (state_r == jtp_pkg::ST_SHIFT_IR) ? ir_sh_r[0] : dr_bit; // RULE2
      end
    end
  end

  // count of consecutive rises with tms high, checked against the reset walk
  always_comb
  begin
    ones_nxt = ones_r;
    if (pin.tck_rise)
    begin
      ones_nxt = !pin.tms ? 3'h0 : (ones_r == jtp_pkg::ONES_MAX) ? ones_r : ones_r + 3'h1;
    end
  end

  // registers
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_r <= jtp_pkg::ST_TLR;
      ir_r <= jtp_pkg::IR_RESET;
      ir_sh_r <= '0;
      byp_r <= 1'b0;
      id_sh_r <= '0;
      usr_sh_r <= '0;
      usr_q_r <= '0;
      upd_r <= 1'b0;
      tdo_r <= 1'b0;
      oe_r <= 1'b0;
      ones_r <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      ir_r <= ir_nxt;
      ir_sh_r <= ir_sh_nxt;
      byp_r <= byp_nxt;
      id_sh_r <= id_sh_nxt;
      usr_sh_r <= usr_sh_nxt;
      usr_q_r <= usr_q_nxt;
      upd_r <= upd_nxt;
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
      ones_r <= ones_nxt;
    end
  end

  assign tdo_out = tdo_r;
  assign tdo_oe_out = oe_r;
  assign instr_out = ir_r;
  assign user_data_out = usr_q_r;
  assign user_update_out = upd_r;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_rise_in_shift_ir;
    pin.tck_rise && state_r == jtp_pkg::ST_SHIFT_IR;
  endsequence
  sequence s_rise_in_byp_shift;
    pin.tck_rise && state_r == jtp_pkg::ST_SHIFT_DR && ir_r == jtp_pkg::INSTR_BYPASS;
  endsequence
  sequence s_user_update;
    pin.tck_rise && state_r == jtp_pkg::ST_UPD_DR && ir_r == jtp_pkg::INSTR_USER && !pin.ce_n;
  endsequence

  a_ir_shift_in: assert property (s_rise_in_shift_ir |=> ir_sh_r[IR_W-1] == $past(pin.tdi)) // RULE1
    else $error("ir shift did not take tdi");
  a_byp_shift_in: assert property (s_rise_in_byp_shift |=> byp_r == $past(pin.tdi)) // RULE1
    else $error("bypass did not take tdi");
  a_tdo_fall_only: assert property ($changed(tdo_r) |-> $past(pin.tck_fall) && $past(shifting)) // RULE2
    else $error("tdo changed outside a falling edge while shifting");
  a_tdo_off_idle: assert property (pin.tck_fall && !shifting |=> !tdo_oe_out) // RULE3
    else $error("tdo driven while not shifting");
  a_tdo_on_shift: assert property (pin.tck_fall && shifting |=> tdo_oe_out ##1 tdo_oe_out) // RULE3
    else $error("tdo not driven while shifting");
  a_state_on_rise: assert property ($changed(state_r) |-> $past(pin.tck_rise)) // RULE4
    else $error("state moved without a rising edge");
  a_tms_steers: assert property (pin.tck_rise && state_r == jtp_pkg::ST_RTI |=>
    state_r == ($past(pin.tms) ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI)) // RULE4
    else $error("wrong move from run test idle");
  a_tms_high_reset: assert property (ones_r == jtp_pkg::ONES_MAX |-> state_r == jtp_pkg::ST_TLR) // RULE6
    else $error("five tms high rises did not reach reset state");
  a_tlr_instr: assert property (state_r == jtp_pkg::ST_TLR && pin.tck_rise |=>
    instr_out == jtp_pkg::IR_RESET) // RULE8
    else $error("reset state did not load default instruction");
  a_user_update: assert property (s_user_update |=> user_update_out ##1 !user_update_out) // RULE7
    else $error("user update pulse wrong");
endmodule

// [dv/jtp_host_model.sv]
// Purpose: behavioural test host driving test clock, mode and data pins
// Assumes: test clock period 160 ns; tdo is sampled at the rising test clock edge
// Notes: between frames the clock stands low and tdi rests high; tms rests high after a scan, low after to_idle
module jtp_host_model (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic chip_enable_n_out,
  input wire logic tdo_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ce_block = 1'b0;

  // quiet pins from time zero, steady through device reset
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // enable held low while programming unless a test blocks it
  assign chip_enable_n_out = ce_block;

  // one clock period, tms and tdi set up a quarter period before the rise
  // and a quarter period after the fall, so a rest level and the next bit
  // never land in one time step
  task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
    #40;
    tms_out = tms_v;
    tdi_out = tdi_v;
    #40 tck_out = 1'b1;
    tdo_v = tdo_in;
    #80 tck_out = 1'b0;
  endtask

  // five tms-high clocks, then one low into run-test-idle
  task automatic to_idle();
    logic d;
    repeat (jtp_pkg::RESET_TMS_RISES) tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
  endtask

  // scan from run-test-idle back to run-test-idle, lsb first
  task automatic scan(input bit is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic d;
    dout = '0;
    tick(1'b1, 1'b1, d);
    if (is_ir)
      tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
    tick(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
    tms_out = 1'b1;
    tdi_out = 1'b1;
  endtask
endmodule

// [dv/jtp_tap_port_bench.sv]
// Purpose: self-checking bench for the test access port
// Assumes: host model owns tck, tms, tdi and the chip enable
// Notes: expectations come from bench functions and package constants
module jtp_tap_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic tck, tms, tdi, ce_n, tdo, tdo_oe, user_update;
  logic [7:0] user_capture = 8'h00;
  logic [7:0] user_data;
  logic [7:0] d8;
  logic [3:0] instr;
  logic [31:0] so;
  wire logic tdo_pad;
  int errors = 0;
  int cmp_count = 0;
  int upd_cnt = 0;

  always #2 core_clk_in = ~core_clk_in;

  // a released pad shows the inverse of its last value
  assign tdo_pad = tdo_oe ? tdo : ~tdo;

  jtp_tap_port u_jtp_tap_port (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .chip_enable_n_in(ce_n),
    .user_capture_in(user_capture), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .instr_out(instr), .user_data_out(user_data), .user_update_out(user_update));

  jtp_host_model u_jtp_host_model (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .chip_enable_n_out(ce_n), .tdo_in(tdo_pad));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // bypass captures zero and delays the stream by one bit
  function automatic logic [31:0] bypass_exp(input logic [7:0] din);
    return {23'h0, din, 1'b0} & 32'h0000_00ff;
  endfunction

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // tdo may only move while the test clock is low
  always @(tdo or tdo_oe)
    if (srst_in === 1'b0)
      check(tck, 1'b0, "tdo moved with tck high");

  // count user update pulses
  always @(posedge core_clk_in)
    if (user_update === 1'b1)
      upd_cnt++;

  // watchdog, several times the expected run of some 30 us
  initial
  begin
    #200000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    d8 = 8'($urandom(32'h5383));
    repeat (6) @(posedge core_clk_in);
    #1 srst_in = 1'b0;
    repeat (20) @(posedge core_clk_in);
    check(instr, jtp_pkg::IR_RESET, "reset instr");
    check(tdo_oe, 1'b0, "reset tdo released");
    check(user_data, 8'h00, "reset user data");
    $display("test reset done");
    #1;
    u_jtp_host_model.to_idle();
    u_jtp_host_model.scan(1'b1, 4, {28'h0, jtp_pkg::INSTR_USER}, so);
    repeat (8) @(posedge core_clk_in);
    check(so, {28'h0, jtp_pkg::IR_CAPTURE}, "ir capture");
    check(instr, jtp_pkg::INSTR_USER, "ir load");
    check(tdo_oe, 1'b0, "tdo released after ir");
    $display("test ir done");
    for (int n = 0; n < 6; n++)
    begin
      @(posedge core_clk_in) #1;
      user_capture = 8'($urandom);
      d8 = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : 8'($urandom);
      u_jtp_host_model.scan(1'b0, 8, {24'h0, d8}, so);
      repeat (8) @(posedge core_clk_in);
      check(so, {24'h0, user_capture}, "user capture");
      check(user_data, d8, "user update");
      check(tdo_oe, 1'b0, "tdo released after dr");
    end
    check(upd_cnt, 6, "update pulses");
    $display("test user done");
    #1;
    u_jtp_host_model.ce_block = 1'b1;
    u_jtp_host_model.scan(1'b0, 8, {24'h0, ~d8}, so);
    repeat (8) @(posedge core_clk_in);
    #1;
    check(user_data, d8, "blocked update");
    check(upd_cnt, 6, "blocked pulse");
    u_jtp_host_model.ce_block = 1'b0;
    $display("test enable done");
    u_jtp_host_model.scan(1'b1, 4, {28'h0, jtp_pkg::INSTR_BYPASS}, so);
    d8 = 8'($urandom);
    u_jtp_host_model.scan(1'b0, 8, {24'h0, d8}, so);
    check(so, bypass_exp(d8), "bypass");
    $display("test bypass done");
    u_jtp_host_model.to_idle();
    repeat (8) @(posedge core_clk_in);
    #1;
    check(instr, jtp_pkg::INSTR_IDCODE, "five tms reset");
    u_jtp_host_model.scan(1'b0, 32, 32'hffff_ffff, so);
    check(so, jtp_pkg::ID_CODE_DEFAULT, "idcode");
    repeat (200) @(posedge core_clk_in);
    check(tdo_oe, 1'b0, "idle pins quiet");
    check(instr, jtp_pkg::INSTR_IDCODE, "idle instr kept");
    $display("test idcode done");
    print_verdict();
  end
endmodule
